// *** rtl/flash_host_pkg.sv ***
package flash_host_pkg;

  // Clock rate and bus timing, kept as times and as derived cycle counts.
  localparam int CLK_PERIOD_NS = 20;
  localparam int ADDRESS_ACCESS_TIME_NS = 90;
  localparam int CHIP_SELECT_ACCESS_TIME_NS = 90;
  localparam int RESET_PULSE_MIN_NS = 500;
  localparam int RESET_TO_READ_DELAY_NS = 50;
  localparam int WRITE_PULSE_NS = 60;
  localparam int STANDBY_EXTRA_NS = 30;
  localparam int PROTECT_PULSE_NS = 100000;

  // Least times round up to whole cycles.
  function automatic int cyclesUp(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int READ_CYCLES = cyclesUp(ADDRESS_ACCESS_TIME_NS);
  localparam int RESET_CYCLES = cyclesUp(RESET_PULSE_MIN_NS);
  localparam int RECOVER_CYCLES = cyclesUp(RESET_TO_READ_DELAY_NS);
  localparam int WRITE_CYCLES = cyclesUp(WRITE_PULSE_NS);
  localparam int IDLE_CYCLES = cyclesUp(ADDRESS_ACCESS_TIME_NS
                                        + STANDBY_EXTRA_NS);
  localparam int PROTECT_CYCLES_DEFAULT = cyclesUp(PROTECT_PULSE_NS);

  localparam int ADDR_W = 22;
  localparam int DATA_W = 8;
  localparam int CNT_W = 16;

  // Address bit positions used by the signature and protection modes.
  localparam int A0_POS = 0;
  localparam int A1_POS = 1;
  localparam int A6_POS = 6;
  localparam int GROUP_LSB = 16;
  localparam int GROUP_W = 6;

  // Reset values of the pin drivers, and the byte that an unprotected group reads.
  localparam logic [ADDR_W-1:0] ADDR_RESET = 22'h000000;
  localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;
  localparam logic [DATA_W-1:0] UNPROTECTED_CODE = 8'h00;

  // Commands accepted on the host's request port.
  typedef enum logic [2:0] {
    CMD_READ,
    CMD_WRITE,
    CMD_RESET,
    CMD_PROTECT,
    CMD_UNPROTECT,
    CMD_SIG_READ,
    CMD_PROT_CHECK,
    CMD_STANDBY
  } cmd_type;

endpackage

// *** rtl/cycle_timer_if.sv ***
`timescale 1ns/100ps
`default_nettype none
interface cycle_timer_if;
  import flash_host_pkg::*;
  logic load;
  logic [CNT_W-1:0] count;
  logic done;
  modport owner (output load, output count, input done);
  modport timer (input load, input count, output done);
endinterface
`default_nettype wire

// *** rtl/cycle_timer.sv ***
`timescale 1ns/100ps
`default_nettype none
module cycle_timer
  import flash_host_pkg::*;
(
  input wire logic clk_sys,
  input wire logic srst,
  cycle_timer_if.timer tmr
);
  logic [CNT_W-1:0] left_q, left_d;
  logic done_q, done_d;

  // Counts a loaded number of cycles down and pulses done at zero.
  always_comb
  begin
    left_d = left_q;
    done_d = 1'b0;
    if (tmr.load)
    begin
      left_d = tmr.count;
    end
    else if (left_q == 16'h0001)
    begin
      left_d = 16'h0000;
      done_d = 1'b1;
    end
    else if (left_q != 16'h0000)
    begin
      left_d = left_q - 16'h0001;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      left_q <= 16'h0000;
      done_q <= 1'b0;
    end
    else
    begin
      left_q <= left_d;
      done_q <= done_d;
    end
  end

  assign tmr.done = done_q;
endmodule
`default_nettype wire

// *** rtl/flash_host_ctrl.sv ***
`timescale 1ns/100ps
`default_nettype none
module flash_host_ctrl
  import flash_host_pkg::*;
#(
  parameter int PROTECT_CYCLES = PROTECT_CYCLES_DEFAULT
)
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic reqValid,
  input wire cmd_type reqCmd,
  input wire logic [ADDR_W-1:0] reqAddr,
  input wire logic [DATA_W-1:0] reqData,
  input wire logic tempUnprotect,
  output logic reqReady,
  output logic rspValid,
  output logic [DATA_W-1:0] rspData,
  output logic rspInterrupted,
  output logic flashSelectN,
  output logic flashGateN,
  output logic flashGateHv,
  output logic flashStrobeN,
  output logic flashResetN,
  output logic flashResetHv,
  output logic [ADDR_W-1:0] flashAddr,
  output logic flashA9Hv,
  output logic [DATA_W-1:0] flashDataOut,
  output logic flashDataOe,
  input wire logic [DATA_W-1:0] flashDataIn,
  input wire logic readyBusyOut
);
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_READ,
    ST_WRITE,
    ST_RESET,
    ST_RECOVER,
    ST_HVPULSE,
    ST_STANDBY
  } state_type;

  state_type state_q, state_d;
  cmd_type cmd_q, cmd_d;
  logic reqReady_q, reqReady_d, rspValid_q, rspValid_d;
  logic [DATA_W-1:0] rspData_q, rspData_d;
  logic rspInt_q, rspInt_d, busyAtReset_q, busyAtReset_d;
  logic selN_q, selN_d, gateN_q, gateN_d, gateHv_q, gateHv_d;
  logic strN_q, strN_d, rstN_q, rstN_d, a9Hv_q, a9Hv_d;
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic [DATA_W-1:0] dOut_q, dOut_d;
  logic dOe_q, dOe_d;
  logic [DATA_W-1:0] dInMeta_q, dInSync_q;
  logic rbMeta_q, rbSync_q, tuMeta_q, tuSync_q;
  cycle_timer_if tmr ();

  cycle_timer u_timer (
    .clk_sys(clk_sys),
    .srst(srst),
    .tmr(tmr)
  );

  // Sizes a cycle count to the width of the shared timer's count.
  function automatic logic [CNT_W-1:0] cnt(input int c);
    return CNT_W'(c);
  endfunction

  // Pin inputs pass two flip-flops before any logic reads them.
  always_ff @(posedge clk_sys)
  begin
    dInMeta_q <= flashDataIn;
    dInSync_q <= dInMeta_q;
    rbMeta_q <= readyBusyOut;
    rbSync_q <= rbMeta_q;
    tuMeta_q <= tempUnprotect;
    tuSync_q <= tuMeta_q;
  end

  // Sequences every pin transaction one request at a time.
  always_comb
  begin
    state_d = state_q;
    cmd_d = cmd_q;
    reqReady_d = 1'b0;
    rspValid_d = 1'b0;
    rspData_d = rspData_q;
    rspInt_d = rspInt_q;
    busyAtReset_d = busyAtReset_q;
    selN_d = selN_q;
    gateN_d = gateN_q;
    gateHv_d = 1'b0;
    strN_d = 1'b1;
    rstN_d = 1'b1;
    a9Hv_d = a9Hv_q;
    addr_d = addr_q;
    dOut_d = dOut_q;
    dOe_d = 1'b0;
    tmr.load = 1'b0;
    tmr.count = 16'h0000;
    unique case (state_q)
      ST_IDLE:
      begin
        // Address stays put while idle so the flash naps on its own.
        selN_d = 1'b1;
        gateN_d = 1'b1;
        a9Hv_d = 1'b0;
        reqReady_d = 1'b1;
        if (reqValid && reqReady_q)
        begin
          reqReady_d = 1'b0;
          cmd_d = reqCmd;
          addr_d = reqAddr;
          dOut_d = reqData;
          rspInt_d = 1'b0;
          tmr.load = 1'b1;
          unique case (reqCmd)
            CMD_READ:
            begin
              selN_d = 1'b0;
              gateN_d = 1'b0;
              tmr.count = cnt(READ_CYCLES);
              state_d = ST_READ;
            end
            CMD_SIG_READ, CMD_PROT_CHECK:
            begin
              // A1 low reads codes, A1 high reads group status.
              addr_d[A1_POS] = (reqCmd == CMD_PROT_CHECK);
              addr_d[A6_POS] = 1'b0;
              a9Hv_d = 1'b1;
              selN_d = 1'b0;
              gateN_d = 1'b0;
              tmr.count = cnt(READ_CYCLES);
              state_d = ST_READ;
            end
            CMD_WRITE:
            begin
              // A write refused by a protected group still ends normally.
              selN_d = 1'b0;
              gateN_d = 1'b1;
              dOe_d = 1'b1;
              strN_d = 1'b0;
              tmr.count = cnt(WRITE_CYCLES);
              state_d = ST_WRITE;
            end
            CMD_PROTECT, CMD_UNPROTECT:
            begin
              // Group on bits 21..16; A6 picks protect or unprotect.
              addr_d[A6_POS] = (reqCmd == CMD_UNPROTECT);
              a9Hv_d = 1'b1;
              selN_d = 1'b0;
              tmr.count = cnt(PROTECT_CYCLES);
              state_d = ST_HVPULSE;
            end
            CMD_RESET:
            begin
              // A busy flash at reset means its operation is lost.
              busyAtReset_d = !rbSync_q;
              rspInt_d = !rbSync_q;
              rstN_d = 1'b0;
              tmr.count = cnt(RESET_CYCLES);
              state_d = ST_RESET;
            end
            CMD_STANDBY:
            begin
              // Standby by holding reset low; outputs then float.
              rstN_d = 1'b0;
              tmr.count = cnt(RESET_CYCLES);
              state_d = ST_STANDBY;
            end
          endcase
        end
      end
      ST_READ:
      begin
        if (tmr.done)
        begin
          // The whole byte is kept, so a cleared group reads zero.
          rspData_d = dInSync_q;
          rspValid_d = 1'b1;
          state_d = ST_IDLE;
        end
      end
      ST_WRITE:
      begin
        dOe_d = 1'b1;
        strN_d = 1'b0;
        if (tmr.done)
        begin
          strN_d = 1'b1; // Data latches on this rising edge.
          rspValid_d = 1'b1;
          state_d = ST_IDLE;
        end
      end
      ST_HVPULSE:
      begin
        // Gate at high voltage; the strobe pulse does the work.
        gateHv_d = 1'b1;
        strN_d = tmr.done;
        if (tmr.done)
        begin
          rspValid_d = 1'b1;
          state_d = ST_IDLE;
        end
      end
      ST_RESET:
      begin
        rstN_d = 1'b0;
        if (tmr.done)
        begin
          rstN_d = 1'b1;
          tmr.load = 1'b1;
          tmr.count = cnt(RECOVER_CYCLES);
          state_d = ST_RECOVER;
        end
      end
      ST_RECOVER:
      begin
        // Busy case waits ready; otherwise the reset-to-read delay.
        if (busyAtReset_q ? rbSync_q : tmr.done)
        begin
          rspValid_d = 1'b1;
          state_d = ST_IDLE;
        end
      end
      ST_STANDBY:
      begin
        rstN_d = 1'b0;
        if (tmr.done)
        begin
          // Release without a recovery wait.
          rstN_d = 1'b1;
          rspValid_d = 1'b1;
          state_d = ST_IDLE;
        end
      end
      default:
      begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // Registers the sequencer and every pin driver except flashResetHv.
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      state_q <= ST_IDLE;
      cmd_q <= CMD_READ;
      reqReady_q <= 1'b0;
      rspValid_q <= 1'b0;
      rspData_q <= DATA_RESET;
      rspInt_q <= 1'b0;
      busyAtReset_q <= 1'b0;
      selN_q <= 1'b1;
      gateN_q <= 1'b1;
      gateHv_q <= 1'b0;
      strN_q <= 1'b1;
      rstN_q <= 1'b1;
      a9Hv_q <= 1'b0;
      addr_q <= ADDR_RESET;
      dOut_q <= DATA_RESET;
      dOe_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      cmd_q <= cmd_d;
      reqReady_q <= reqReady_d;
      rspValid_q <= rspValid_d;
      rspData_q <= rspData_d;
      rspInt_q <= rspInt_d;
      busyAtReset_q <= busyAtReset_d;
      selN_q <= selN_d;
      gateN_q <= gateN_d;
      gateHv_q <= gateHv_d;
      strN_q <= strN_d;
      rstN_q <= rstN_d;
      a9Hv_q <= a9Hv_d;
      addr_q <= addr_d;
      dOut_q <= dOut_d;
      dOe_q <= dOe_d;
    end
  end

  // Temporary unprotection raises the reset pin to high voltage.
  logic resetHv_q;
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      resetHv_q <= 1'b0;
    end
    else
    begin
      resetHv_q <= tuSync_q && rstN_d;
    end
  end

  assign reqReady = reqReady_q;
  assign rspValid = rspValid_q;
  assign rspData = rspData_q;
  assign rspInterrupted = rspInt_q;
  assign flashSelectN = selN_q;
  assign flashGateN = gateN_q;
  assign flashGateHv = gateHv_q;
  assign flashStrobeN = strN_q;
  assign flashResetN = rstN_q;
  assign flashResetHv = resetHv_q;
  assign flashAddr = addr_q;
  assign flashA9Hv = a9Hv_q;
  assign flashDataOut = dOut_q;
  assign flashDataOe = dOe_q;
endmodule
`default_nettype wire

// *** testbench/flash_host_ctrl_sva.sv ***
`timescale 1ns/100ps
`default_nettype none
module flash_host_ctrl_sva
  import flash_host_pkg::*;
#(
  parameter int PROTECT_CYCLES = 4
)
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic reqValid,
  input wire cmd_type reqCmd,
  input wire logic reqReady,
  input wire logic rspValid,
  input wire logic flashSelectN,
  input wire logic flashGateN,
  input wire logic flashGateHv,
  input wire logic flashStrobeN,
  input wire logic flashResetN,
  input wire logic flashResetHv,
  input wire logic [ADDR_W-1:0] flashAddr,
  input wire logic flashA9Hv,
  input wire logic flashDataOe
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  logic take;
  logic [5:0] lowCnt_q;
  logic [5:0] lowCnt_d;
  assign take = reqValid && reqReady;
  // Counts how long the reset pin has been held low, saturating.
  always_comb
  begin
    lowCnt_d = lowCnt_q;
    if (flashResetN)
      lowCnt_d = 6'h00;
    else if (lowCnt_q != 6'h3F)
      lowCnt_d = lowCnt_q + 6'h01;
  end
  // Registers the low-time count.
  always_ff @(posedge clk_sys)
  begin
    lowCnt_q <= srst ? 6'h00 : lowCnt_d;
  end
  a_reset_idle_pins: assert property (disable iff (1'b0) srst |=>
    flashSelectN && flashStrobeN && flashResetN && !flashDataOe && !reqReady)
    else $error("pins not idle after reset");
  a_write_gate_high: assert property (!flashStrobeN |->
    !flashSelectN && (flashGateN || flashGateHv))
    else $error("strobe low without select or with gate low");
  a_read_gate_low: assert property (take && reqCmd == CMD_READ |=>
    (!flashSelectN && !flashGateN && !flashDataOe)[*6] ##1 rspValid)
    else $error("read cycle pins or latency wrong");
  a_write_answer: assert property (take && reqCmd == CMD_WRITE
    |-> ##5 rspValid) else $error("write answer late");
  a_reset_pulse_len: assert property ($rose(flashResetN)
    |-> lowCnt_q >= RESET_CYCLES) else $error("reset pulse too short");
  a_reset_no_data: assert property (!flashResetN |-> !flashDataOe)
    else $error("data driven during reset");
  a_read_after_reset: assert property (!rspValid
    && $rose(flashResetN) |-> flashGateN [*3])
    else $error("read too soon after reset");
  a_protect_pins: assert property (take && reqCmd == CMD_PROTECT
    |-> ##[1:4] (flashGateHv && flashA9Hv && !flashSelectN
    && !flashAddr[A6_POS] && !flashStrobeN)) else $error("protect pins");
  a_unprot_pins: assert property (take && reqCmd == CMD_UNPROTECT
    |-> ##[1:4] (flashGateHv && flashA9Hv && !flashSelectN
    && flashAddr[A6_POS] && !flashStrobeN)) else $error("unprotect pins");
  a_sig_pins: assert property (take && reqCmd == CMD_SIG_READ
    |-> ##[1:4] (flashA9Hv && !flashAddr[A1_POS] && !flashAddr[A6_POS]
    && !flashGateN)) else $error("signature pins");
  a_check_pins: assert property (take && reqCmd == CMD_PROT_CHECK
    |-> ##[1:4] (flashA9Hv && flashAddr[A1_POS] && flashStrobeN
    && !flashGateN)) else $error("protection check pins");
  a_temp_hv_high: assert property (flashResetHv |-> flashResetN)
    else $error("high voltage on a low reset pin");
endmodule
bind flash_host_ctrl flash_host_ctrl_sva #(.PROTECT_CYCLES(PROTECT_CYCLES))
  chk (.clk_sys, .srst, .reqValid, .reqCmd, .reqReady, .rspValid,
  .flashSelectN, .flashGateN, .flashGateHv, .flashStrobeN, .flashResetN,
  .flashResetHv, .flashAddr, .flashA9Hv, .flashDataOe);
`default_nettype wire

// *** testbench/flash_device_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module flash_device_model
  import flash_host_pkg::*;
#(
  parameter logic [7:0] MAKER_CODE = 8'h5E, // Arbitrary value.
  parameter logic [7:0] PART_CODE = 8'h6B // Arbitrary value.
)
(
  input wire logic clk_sys,
  input wire logic flashSelectN,
  input wire logic flashGateN,
  input wire logic flashGateHv,
  input wire logic flashStrobeN,
  input wire logic flashResetN,
  input wire logic flashResetHv,
  input wire logic [ADDR_W-1:0] flashAddr,
  input wire logic flashA9Hv,
  output logic [DATA_W-1:0] flashDataIn,
  output logic readyBusyOut
);
  logic [63:0] prot = 64'h0;
  logic [7:0] val;
  logic [7:0] lastQ = 8'h00;
  logic [5:0] grp;
  logic drive;
  logic strPrev = 1'b1;
  int busy = 0;
  // Outputs float in standby, with gate high and during reset.
  assign drive = !flashSelectN && !flashGateN && flashResetN && !flashGateHv;
  assign grp = flashAddr[21:16];
  assign readyBusyOut = (busy == 0);
  assign flashDataIn = drive ? val : ~lastQ;
  // Signature codes, protection status or array pattern.
  always_comb
  begin
    if (flashA9Hv)
      val = flashAddr[A1_POS] ? {7'h00, prot[grp]} :
        (flashAddr[A0_POS] ? PART_CODE : MAKER_CODE);
    else
      val = flashAddr[7:0] ^ 8'h5A;
  end
  // Busy runs on without select; reset shortens it to the ready time.
  // Strobe edges are seen one clock after the controller moves the pin.
  always @(posedge clk_sys)
  begin
    if (drive)
      lastQ <= val;
    // A write to an open group starts an embedded operation.
    if (strPrev && !flashStrobeN && !flashSelectN && flashGateN
        && flashResetN && !flashA9Hv
        && (!prot[grp] || flashResetHv))
      busy <= 40;
    else if (!flashResetN && busy > 3)
      busy <= 3;
    else if (busy > 0)
      busy <= busy - 1;
    // A high-voltage strobe pulse sets one group or clears them all.
    if (!strPrev && flashStrobeN && !flashSelectN && flashGateHv
        && flashA9Hv)
    begin
      if (flashAddr[A6_POS])
        prot <= 64'h0;
      else
        prot[grp] <= 1'b1;
    end
    strPrev <= flashStrobeN;
  end
endmodule
`default_nettype wire

// *** testbench/flash_host_ctrl_test.sv ***
`timescale 1ns/100ps
`default_nettype none
module flash_host_ctrl_test
  import flash_host_pkg::*;
;
  localparam logic [7:0] MAKER = 8'h5E; // Arbitrary value.
  localparam logic [7:0] PART = 8'h6B; // Arbitrary value.
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic reqValid = 1'b0;
  logic tempUnprotect = 1'b0;
  cmd_type reqCmd = CMD_READ;
  logic [21:0] reqAddr = 22'h000000;
  logic [7:0] reqData = 8'h3C;
  logic reqReady, rspValid, rspInterrupted, flashSelectN, flashGateN;
  logic flashGateHv, flashStrobeN, flashResetN, flashResetHv, flashA9Hv;
  logic flashDataOe, readyBusyOut;
  logic [21:0] flashAddr;
  logic [7:0] rspData, flashDataOut, flashDataIn, d;
  logic intr;
  int n_mismatch = 0;
  int check_count = 0;
  int cyc = 0;
  flash_host_ctrl #(.PROTECT_CYCLES(4)) uut (.clk_sys, .srst, .reqValid,
    .reqCmd, .reqAddr, .reqData, .tempUnprotect, .reqReady, .rspValid,
    .rspData, .rspInterrupted, .flashSelectN, .flashGateN, .flashGateHv,
    .flashStrobeN, .flashResetN, .flashResetHv, .flashAddr, .flashA9Hv,
    .flashDataOut, .flashDataOe, .flashDataIn, .readyBusyOut);
  flash_device_model #(.MAKER_CODE(MAKER), .PART_CODE(PART)) dev (.clk_sys,
    .flashSelectN, .flashGateN, .flashGateHv, .flashStrobeN, .flashResetN,
    .flashResetHv, .flashAddr, .flashA9Hv, .flashDataIn, .readyBusyOut);
  // Clock of 20 ns.
  always #10 clk_sys = ~clk_sys;
  // Cuts a hang short.
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc > 20000)
    begin
      n_mismatch++;
      report_and_stop();
    end
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("mismatches=%0d checks=%0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // One request, taken on a ready edge, then the answer pulse.
  task automatic run(input cmd_type c, input logic [21:0] a);
    int n;
    @(negedge clk_sys);
    reqCmd = c;
    reqAddr = a;
    reqValid = 1'b1;
    n = 0;
    // Ready seen high between edges means the next rising edge takes it.
    while (reqReady !== 1'b1 && n < 100)
    begin
      @(negedge clk_sys);
      n++;
    end
    @(posedge clk_sys);
    @(negedge clk_sys);
    reqValid = 1'b0;
    while (rspValid !== 1'b1 && n < 300)
    begin
      @(negedge clk_sys);
      n++;
    end
    if (rspValid !== 1'b1)
    begin
      n_mismatch++;
      report_and_stop();
    end
    else
    begin
      d = rspData;
      intr = rspInterrupted;
    end
  endtask
  task automatic t_reads();
    run(CMD_READ, 22'h000012);
    chk(d, 8'h48);
    run(CMD_READ, 22'h3F00A5);
    chk(d, 8'hFF);
  endtask
  task automatic t_sig();
    for (int i = 0; i < 2; i++)
    begin
      run(CMD_SIG_READ, 22'(i));
      chk(d, i ? PART : MAKER);
    end
  endtask
  task automatic t_protect();
    run(CMD_PROTECT, 22'h050000);
    run(CMD_PROT_CHECK, 22'h050002);
    chk(d, 8'h01);
    run(CMD_PROT_CHECK, 22'h060002);
    chk(d, 8'h00);
  endtask
  task automatic t_write_reset(input logic [21:0] a, input logic busy);
    reqData = a[7:0];
    run(CMD_WRITE, a);
    chk(flashDataOut, a[7:0]);
    chk({7'h00, flashStrobeN}, 8'h01);
    run(CMD_RESET, 22'h000000);
    chk({7'h00, intr}, {7'h00, busy});
    run(CMD_READ, a);
    chk(d, a[7:0] ^ 8'h5A);
  endtask
  task automatic t_temp();
    tempUnprotect = 1'b1;
    repeat (4) @(negedge clk_sys);
    chk({7'h00, flashResetHv}, 8'h01);
    t_write_reset(22'h050033, 1'b1);
    tempUnprotect = 1'b0;
  endtask
  task automatic t_unprotect();
    for (int g = 0; g < 64; g++)
    begin
      run(CMD_PROTECT, 22'(g) << 16);
    end
    run(CMD_PROT_CHECK, 22'h3F0002);
    chk(d, 8'h01);
    run(CMD_UNPROTECT, 22'h000000);
    for (int g = 0; g < 64; g++)
    begin
      run(CMD_PROT_CHECK, (22'(g) << 16) | 22'h000002);
      chk(d, 8'h00);
    end
  endtask
  task automatic t_standby();
    run(CMD_STANDBY, 22'h000000);
    chk({7'h00, flashSelectN}, 8'h01);
    run(CMD_READ, 22'h000077);
    chk(d, 8'h2D);
  endtask
  // Main sequence.
  initial
  begin
    repeat (2) @(negedge clk_sys);
    srst = 1'b0;
    t_reads();
    t_sig();
    t_protect();
    t_write_reset(22'h050011, 1'b0);
    t_write_reset(22'h060022, 1'b1);
    t_temp();
    t_unprotect();
    t_write_reset(22'h050044, 1'b1);
    t_standby();
    report_and_stop();
  end
endmodule
`default_nettype wire
